/* File: hdl/wdtc_prescale.sv */
// wdtc_prescale: watchdog tick generator, every clock or one in DIV clocks
// assumes clear and div_en are synchronous to aclk
`default_nettype none

module wdtc_prescale
	import wdtc_pkg::*;
#(
	parameter int unsigned DIV = WDTC_PRESC_DIV
)
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic clear,
	input  wire logic div_en,
	// tick out
	output var  logic tick_q
);

	localparam int PW = $clog2(DIV);

	logic [PW-1:0] pcnt_q;
	logic [PW-1:0] pcnt_d;
	logic          tick_d;

	// next divider count and tick
	always_comb
	begin
		pcnt_d = '0;
		tick_d = 1'b0;
		if (!clear && !div_en)
		begin
			tick_d = 1'b1;
		end
		else if (!clear)
		begin
			// wrap at DIV so a divisor that is not a power of two keeps its period
			tick_d = (pcnt_q == PW'(DIV - 1));
			pcnt_d = tick_d ? '0 : pcnt_q + PW'(1);
		end
	end

	// divider registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pcnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			pcnt_q <= pcnt_d;
			tick_q <= tick_d;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/wdtc_top.sv */
// wdtc_top: watchdog timeout control with one AXI4-Lite control word
// assumes a single clock aclk; por_resetn is a power-on reset that the
// watchdog reset request does not reach, so the reset cause survives it
//
// How it works
// - interval codes 01/10/11 give 2^16/2^18/2^20 ticks; reset follows later
// - timeout sets the interrupt flag; software clears it by writing one
// - the interrupt flag is set on timeout even with interrupt disabled
// - a watchdog reset request sets the reset cause flag
// - reset cause flag holds until software clears it
// - with reset function disabled the reset cause flag is never set
// - reset function enable bit allows or blocks the reset request
// - writing one to counter restart zeroes the count; zero does nothing
// - counter restart is self-clearing and always reads as zero
// - software must restart in time, else interrupt at timeout if enabled
// - reset follows timeout after a delay; 512 conflicts with 1024 elsewhere
// - reset timeout is always 1024 ticks after interrupt timeout; 00 is 2^14
// - counter runs only while timer run enable is one
// - interrupt output follows the flag only while interrupt enable is one
// - prescale select divides ticks by 256 unless test mode is selected
`default_nettype none

module wdtc_top
	import wdtc_pkg::*;
#(
	parameter int          ADDR_W      = 8,
	parameter int unsigned TOUT_00     = WDTC_TOUT_00,
	parameter int unsigned TOUT_01     = WDTC_TOUT_01,
	parameter int unsigned TOUT_10     = WDTC_TOUT_10,
	parameter int unsigned TOUT_11     = WDTC_TOUT_11,
	parameter int unsigned RESET_DELAY = WDTC_RST_DELAY,
	parameter int unsigned PRESC_DIV   = WDTC_PRESC_DIV
)
(
	// clock and resets
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              por_resetn,
	// axi write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	// axi write response
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// system outputs
	output var  logic              wdt_irq,
	output var  logic              wdt_reset_req
);

	localparam int CW = WDTC_CNT_W;

	// bus slave state
	logic              awready_q, awready_d, wready_q, wready_d;
	logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0]       w_data_q, w_data_d;
	logic [3:0]        w_strb_q, w_strb_d;
	logic              bvalid_q, bvalid_d, arready_q, arready_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              do_wr, wr_hit, rd_hit;

	// watchdog state
	wdtc_ctrl_t        ctrl_q, ctrl_d;
	wdtc_state_t       state_q, state_d;
	logic [CW-1:0]     cnt_q, cnt_d, tout_w;
	logic              irq_flag_q, irq_flag_d, rst_flag_q, rst_flag_d;
	logic              irq_q, irq_d, rreq_q, rreq_d;
	logic              tick_w, run_tick, restart_w, irq_evt, end_evt, rst_evt;
	logic              clr_irq_w, clr_rst_w;
	logic [31:0]       ctrl_rd;

	// write address decode and software strobes
	assign do_wr     = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_hit    = do_wr && ({aw_addr_q[ADDR_W-1:2], 2'b00} == ADDR_W'(WDTC_CTRL_OFS));
	assign rd_hit    = ({s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(WDTC_CTRL_OFS));
	assign restart_w = wr_hit && w_strb_q[0] && w_data_q[WDTC_BIT_RESTART];
	assign clr_irq_w = wr_hit && w_strb_q[0] && w_data_q[WDTC_BIT_IRQ_FLAG];
	assign clr_rst_w = wr_hit && w_strb_q[0] && w_data_q[WDTC_BIT_RST_FLAG];

	// readback image of the control word
	always_comb
	begin
		ctrl_rd                                  = '0;
		ctrl_rd[WDTC_BIT_RST_EN]                 = ctrl_q.rst_en;
		ctrl_rd[WDTC_BIT_RST_FLAG]               = rst_flag_q;
		ctrl_rd[WDTC_BIT_IRQ_FLAG]               = irq_flag_q;
		ctrl_rd[WDTC_BIT_ISEL_LO+1:WDTC_BIT_ISEL_LO] = ctrl_q.isel;
		ctrl_rd[WDTC_BIT_IRQ_EN]                 = ctrl_q.irq_en;
		ctrl_rd[WDTC_BIT_RUN_EN]                 = ctrl_q.run_en;
		ctrl_rd[WDTC_BIT_TEST]                   = ctrl_q.test;
		ctrl_rd[WDTC_BIT_PRESC]                  = ctrl_q.presc;
	end

	// axi next state: channels taken independently, response after both
	always_comb
	begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d  = w_hold_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		if (s_axi_awvalid && awready_q)
		begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q)
		begin
			w_hold_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (do_wr)
		begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_hit ? WDTC_RESP_OKAY : WDTC_RESP_SLVERR;
		end
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = rd_hit ? WDTC_RESP_OKAY : WDTC_RESP_SLVERR;
			rdata_d  = rd_hit ? ctrl_rd : 32'h0000_0000;
		end
		awready_d = !aw_hold_d;
		wready_d  = !w_hold_d;
		arready_d = !rvalid_d;
	end

	// axi registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_hold_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= WDTC_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= WDTC_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end
		else
		begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			aw_hold_q <= aw_hold_d;
			aw_addr_q <= aw_addr_d;
			w_hold_q  <= w_hold_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// tick source; a restart also clears the divider
	// divide by 256 when prescale is set, unless test mode
	wdtc_prescale #(
		.DIV    (PRESC_DIV)
	) u_presc (
		.aclk   (aclk),
		.aresetn(aresetn),
		.clear  (restart_w),
		.div_en (ctrl_q.presc && !ctrl_q.test),
		.tick_q (tick_w)
	);

	always_comb
	begin
		unique case (ctrl_q.isel)
			WDTC_ISEL_00: tout_w = CW'(TOUT_00); // 00
			WDTC_ISEL_01: tout_w = CW'(TOUT_01);
			WDTC_ISEL_10: tout_w = CW'(TOUT_10);
			WDTC_ISEL_11: tout_w = CW'(TOUT_11);
		endcase
	end

	// count only while run enable set
	assign run_tick = ctrl_q.run_en && tick_w;
	// timeout when count reaches the interval
	assign irq_evt  = run_tick && (state_q == WDTC_ST_RUN) && (cnt_q >= tout_w - CW'(1));
	// reset timeout a fixed delay after the interrupt timeout
	assign end_evt  = run_tick && (state_q == WDTC_ST_GRACE)
		&& (cnt_q >= tout_w + CW'(RESET_DELAY) - CW'(1));
	// reset function gated by its enable
	assign rst_evt  = end_evt && ctrl_q.rst_en;

	// control word, counter and flags next state
	always_comb
	begin
		ctrl_d  = ctrl_q;
		cnt_d   = cnt_q;
		state_d = state_q;
		if (wr_hit && w_strb_q[0])
		begin
			ctrl_d.rst_en = w_data_q[WDTC_BIT_RST_EN];
			ctrl_d.isel   = w_data_q[WDTC_BIT_ISEL_LO+1:WDTC_BIT_ISEL_LO];
			ctrl_d.irq_en = w_data_q[WDTC_BIT_IRQ_EN];
			ctrl_d.run_en = w_data_q[WDTC_BIT_RUN_EN];
		end
		if (wr_hit && w_strb_q[1])
		begin
			ctrl_d.test  = w_data_q[WDTC_BIT_TEST];
			ctrl_d.presc = w_data_q[WDTC_BIT_PRESC];
		end
		// restart zeroes the count; the bit itself is not stored
		if (restart_w)
		begin
			cnt_d   = '0;
			state_d = WDTC_ST_RUN;
		end
		else
		begin
			unique case (state_q)
				WDTC_ST_RUN:
				begin
					if (run_tick)
						cnt_d = cnt_q + CW'(1);
					if (irq_evt)
						state_d = WDTC_ST_GRACE;
				end
				WDTC_ST_GRACE:
				begin
					if (run_tick)
						cnt_d = cnt_q + CW'(1);
					// reset issued at end of grace delay
					if (end_evt)
						state_d = WDTC_ST_HALT;
				end
				WDTC_ST_HALT:
					cnt_d = cnt_q; // waits for a restart
			endcase
		end
		// flag set on timeout whatever the enable; set wins clear
		irq_flag_d = irq_evt || (irq_flag_q && !clr_irq_w);
		// only a reset event sets it, only software clears
		rst_flag_d = rst_evt || (rst_flag_q && !clr_rst_w);
		// interrupt out gated by its enable
		irq_d      = irq_flag_d && ctrl_d.irq_en;
		rreq_d     = rst_evt;
	end

	// watchdog registers on the bus reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q     <= WDTC_CTRL_RST;
			cnt_q      <= '0;
			state_q    <= WDTC_ST_RUN;
			irq_flag_q <= 1'b0;
			irq_q      <= 1'b0;
			rreq_q     <= 1'b0;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			cnt_q      <= cnt_d;
			state_q    <= state_d;
			irq_flag_q <= irq_flag_d;
			irq_q      <= irq_d;
			rreq_q     <= rreq_d;
		end
	end

	// reset cause survives the system reset it requested
	always_ff @(posedge aclk)
	begin
		if (!por_resetn)
			rst_flag_q <= 1'b0;
		else
			rst_flag_q <= rst_flag_d;
	end

	// outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign wdt_irq       = irq_q;
	assign wdt_reset_req = rreq_q;

	// checks on the bus clock
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_restart_zero: assert property (
		restart_w |=> (cnt_q == '0) && (state_q == WDTC_ST_RUN))
		else $error("restart did not zero the count");
	chk_restart_reads: assert property (
		s_axi_rvalid && (s_axi_rresp == WDTC_RESP_OKAY) |-> !s_axi_rdata[WDTC_BIT_RESTART])
		else $error("restart bit read back as one");
	chk_flag_on_tout: assert property (
		$rose(irq_flag_q) |-> $past(irq_evt) && ($past(cnt_q) >= $past(tout_w) - CW'(1)))
		else $error("interrupt flag rose without timeout");
	chk_irq_gate: assert property (
		wdt_irq |-> irq_flag_q && ctrl_q.irq_en)
		else $error("interrupt out without flag and enable");
	chk_rflag_cause: assert property (
		@(posedge aclk) disable iff (!por_resetn)
		$rose(rst_flag_q) |-> $past(ctrl_q.rst_en) && wdt_reset_req)
		else $error("reset cause set without enabled reset");
	chk_rflag_hold: assert property (
		@(posedge aclk) disable iff (!por_resetn)
		$fell(rst_flag_q) |-> $past(clr_rst_w))
		else $error("reset cause cleared without software");
	chk_run_stop: assert property (
		!ctrl_q.run_en && !restart_w |=> $stable(cnt_q))
		else $error("counter moved while stopped");
	chk_grace_len: assert property (
		$rose(wdt_reset_req) |-> $past(state_q) == WDTC_ST_GRACE
			&& $past(cnt_q) >= $past(tout_w) + CW'(RESET_DELAY) - CW'(1))
		else $error("reset request not after grace delay");
	chk_prescale_gap: assert property (
		$past(ctrl_q.presc && !ctrl_q.test) && ctrl_q.presc && !ctrl_q.test
			&& tick_w |=> !tick_w)
		else $error("divided ticks came back to back");

endmodule

`default_nettype wire

/* File: pkg/wdtc_pkg.sv */
// wdtc_pkg: constants and types shared by the watchdog control block
// assumes a 32-bit AXI4-Lite register bus and one clock domain
`default_nettype none

package wdtc_pkg;

	// register map: one control word
	localparam logic [7:0] WDTC_CTRL_OFS = 8'h00;

	// control word field positions
	localparam int WDTC_BIT_RESTART  = 0;
	localparam int WDTC_BIT_RST_EN   = 1;
	localparam int WDTC_BIT_RST_FLAG = 2;
	localparam int WDTC_BIT_IRQ_FLAG = 3;
	localparam int WDTC_BIT_ISEL_LO  = 4;
	localparam int WDTC_BIT_IRQ_EN   = 6;
	localparam int WDTC_BIT_RUN_EN   = 7;
	localparam int WDTC_BIT_TEST     = 8;
	localparam int WDTC_BIT_PRESC    = 10;

	// interval select codes
	localparam logic [1:0] WDTC_ISEL_00 = 2'h0;
	localparam logic [1:0] WDTC_ISEL_01 = 2'h1;
	localparam logic [1:0] WDTC_ISEL_10 = 2'h2;
	localparam logic [1:0] WDTC_ISEL_11 = 2'h3;

	// timing counts in watchdog ticks
	localparam int unsigned WDTC_TOUT_00       = 2**14;
	localparam int unsigned WDTC_TOUT_01       = 2**16;
	localparam int unsigned WDTC_TOUT_10       = 2**18;
	localparam int unsigned WDTC_TOUT_11       = 2**20;
	localparam int unsigned WDTC_RST_DELAY     = 1024;
	localparam int unsigned WDTC_RST_DELAY_ALT = 512;
	localparam int unsigned WDTC_PRESC_DIV     = 256;
	localparam int          WDTC_CNT_W         = 21;

	// axi responses
	localparam logic [1:0] WDTC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] WDTC_RESP_SLVERR = 2'h2;

	// software-visible control bits
	typedef struct packed {
		logic       presc;
		logic       test;
		logic       run_en;
		logic       irq_en;
		logic [1:0] isel;
		logic       rst_en;
	} wdtc_ctrl_t;

	localparam wdtc_ctrl_t WDTC_CTRL_RST = '0;

	// counter sequencing states
	typedef enum logic [2:0] {
		WDTC_ST_RUN   = 3'b001,
		WDTC_ST_GRACE = 3'b010,
		WDTC_ST_HALT  = 3'b100
	} wdtc_state_t;

endpackage

`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: self-checking bench for the watchdog control block
// assumes wdtc_pkg is compiled first and wdtc_top is shortened by parameters
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module testbench
	import wdtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int T00 = 16;
	localparam int T01 = 32;
	localparam int T10 = 64;
	localparam int T11 = 128;
	localparam int DLY = 8;
	localparam int DIV = 4;
	// control word bits
	localparam logic [31:0] RST = 32'h0000_0001;
	localparam logic [31:0] REN = 32'h0000_0002;
	localparam logic [31:0] RFL = 32'h0000_0004;
	localparam logic [31:0] IFL = 32'h0000_0008;
	localparam logic [31:0] IEN = 32'h0000_0040;
	localparam logic [31:0] RUN = 32'h0000_0080;
	localparam logic [31:0] TST = 32'h0000_0100;
	localparam logic [31:0] PRE = 32'h0000_0400;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        por_resetn = 1'b0;
	logic [7:0]  awaddr = '0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic [3:0]  strb_sel = 4'hf;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = '0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        wdt_irq;
	logic        wdt_reset_req;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          rst_cnt = 0;
	int          rst_t = 0;

	wdtc_top #(.ADDR_W(8), .TOUT_00(T00), .TOUT_01(T01), .TOUT_10(T10), .TOUT_11(T11),
		.RESET_DELAY(DLY), .PRESC_DIV(DIV)) uut (
		.aclk(aclk), .aresetn(aresetn), .por_resetn(por_resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

	// 25 MHz clock
	always #20 aclk = ~aclk;

	// cycle count and reset request pulse log
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (wdt_reset_req === 1'b1)
		begin
			rst_cnt <= rst_cnt + 1;
			rst_t   <= cyc;
		end
	end

	task automatic end_sim();
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one axi4-lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_on;
		logic w_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= strb_sel;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_on || w_on)
		begin
			@(posedge aclk);
			if (aw_on && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				w_on = 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	// one axi4-lite read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// write the control word and expect an okay response
	task automatic ctl(input logic [31:0] d);
		logic [1:0] r;
		wr(WDTC_CTRL_OFS, d, r);
		`CHK(r, WDTC_RESP_OKAY)
	endtask

	// read the control word and compare it
	task automatic expect_ctl(input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(WDTC_CTRL_OFS, d, r);
		`CHK(d, e)
		`CHK(r, WDTC_RESP_OKAY)
	endtask

	// restart, then count cycles until the interrupt output rises
	task automatic time_irq(input logic [31:0] c, input int lim, output int n);
		ctl(c | RST);
		n = 0;
		while (wdt_irq !== 1'b1 && n < lim)
		begin
			@(posedge aclk);
			n++;
		end
	endtask

	initial
	begin
		int         n;
		int         t0;
		int         touts[4];
		logic [31:0] d;
		logic [1:0]  r;
		touts = '{T00, T01, T10, T11};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		por_resetn <= 1'b1;
		repeat (2) @(posedge aclk);
		expect_ctl(32'h0000_0000);
		// unmapped place refused with slave error
		wr(8'h04, RUN, r);
		`CHK(r, WDTC_RESP_SLVERR)
		rd(8'h10, d, r);
		`CHK(d, 32'h0000_0000)
		`CHK(r, WDTC_RESP_SLVERR)
		expect_ctl(32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			time_irq(RUN | IEN | (i << 4), 400, n);
			`CHK(n >= touts[i] - 2 && n <= touts[i] + 3, 1'b1)
			expect_ctl(RUN | IEN | (i << 4) | IFL);
			ctl(IFL);
			expect_ctl(32'h0000_0000);
		end
		`CHK(rst_cnt, 0)
		ctl(RUN | RST);
		repeat (T00 + 6) @(posedge aclk);
		`CHK(wdt_irq, 1'b0)
		expect_ctl(RUN | IFL);
		ctl(RUN | IEN);
		repeat (3) @(posedge aclk);
		`CHK(wdt_irq, 1'b1)
		ctl(IFL);
		ctl(RST);
		repeat (3 * T00) @(posedge aclk);
		expect_ctl(32'h0000_0000);
		// restarts in time keep the flag clear
		ctl(RUN | RST);
		repeat (5)
		begin
			repeat (T00 / 2) @(posedge aclk);
			ctl(RUN | RST);
		end
		expect_ctl(RUN);
		ctl(RUN);
		repeat (T00 + 4) @(posedge aclk);
		expect_ctl(RUN | IFL);
		ctl(IFL);
		time_irq(RUN | REN | IEN, 100, n);
		t0 = cyc;
		repeat (DLY + 6) @(posedge aclk);
		`CHK(rst_cnt, 1)
		`CHK(rst_t - t0 >= DLY - 2 && rst_t - t0 <= DLY + 2, 1'b1)
		expect_ctl(RUN | REN | IEN | IFL | RFL);
		// cause flag survives the system reset
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		expect_ctl(RFL);
		// no reset function, flag and request unchanged
		ctl(RUN | RST);
		repeat (T00 + DLY + 8) @(posedge aclk);
		`CHK(rst_cnt, 1)
		expect_ctl(RUN | IFL | RFL);
		ctl(IFL | RFL);
		expect_ctl(32'h0000_0000);
		// divided ticks, and test mode ignoring the divider
		time_irq(RUN | IEN | PRE, 200, n);
		`CHK(n >= T00 * DIV - 2 && n <= T00 * DIV + 8, 1'b1)
		ctl(IFL);
		time_irq(RUN | IEN | PRE | TST, 200, n);
		`CHK(n >= T00 - 2 && n <= T00 + 3, 1'b1)
		ctl(IFL);
		// lane 1 strobe off: test and prescale bits keep their cleared values
		strb_sel = 4'h1;
		ctl(RUN | PRE | TST);
		strb_sel = 4'hf;
		expect_ctl(RUN);
		end_sim();
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		end_sim();
	end

endmodule

`undef CHK
`default_nettype wire
